// ==== design/pia_pkg.sv ====
// package: constants and types for the host bus and register select block
// Summary of operation
// RULE1 - selected only when both high selects are high and the low select low
// RULE2 - code 00: side A port output if A control bit 2, else direction
// RULE3 - code 10: side B port output if B control bit 2, else direction
// RULE4 - code 01 picks side A control, code 11 side B control, always
// RULE5 - bit7 flag one, bit6 flag two, 5:3 line two, 2 access, 1:0 line one
// RULE6 - every host transfer is timed by the phase-two clock only
// RULE7 - the processor generates and supplies the phase-two clock
// RULE8 - selected read drives the addressed register through the bus buffer
// RULE9 - on writes the data lines stay inputs; processor drives the byte
// RULE10 - data lines float whenever the chip-select condition is not met
// RULE11 - direction and target follow read/write, selects and controls
// RULE12 - read/write high means read, low means write
// RULE13 - low reset pin clears every register, making all port lines inputs
// RULE14 - a direction bit of one makes its port line an output
// RULE15 - written byte lands only after the phase-two trailing edge
// RULE16 - a selected write updates only the single addressed register
package pia_pkg;

    // ------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------
    localparam int CTL_FLAG1_BIT = 7;
    localparam int CTL_FLAG2_BIT = 6;
    localparam int CTL_DIR_ACCESS_BIT = 2;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h3F;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // register select codes {reg_sel_hi, reg_sel_lo}
    // ------------------------------------------------------------
    localparam logic [1:0] RS_SIDE_A = 2'b00;
    localparam logic [1:0] RS_CTL_A = 2'b01;
    localparam logic [1:0] RS_SIDE_B = 2'b10;
    localparam logic [1:0] RS_CTL_B = 2'b11;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TGT_DIR_A = 3'b000,
        TGT_PORT_A = 3'b001,
        TGT_CTL_A = 3'b010,
        TGT_DIR_B = 3'b100,
        TGT_PORT_B = 3'b101,
        TGT_CTL_B = 3'b110
    } target_t;

    typedef enum logic [1:0] {
        PH_LOW = 2'b00,
        PH_HIGH = 2'b01
    } phase_t;

    // host pins after sampling; field order fixes the reset pattern below
    typedef struct packed {
        logic phase_two_clk;
        logic select_high_a;
        logic select_high_b;
        logic select_low_n;
        logic reg_sel_hi;
        logic reg_sel_lo;
        logic read_write_n;
        logic reset_n;
        logic [7:0] data;
    } host_pins_t;

    // idle pins: low select and reset pin held inactive
    localparam logic [15:0] PINS_RESET = 16'h1100;

    // access latched at the phase-two rising edge
    typedef struct packed {
        logic selected;
        logic read;
        target_t target;
        logic [7:0] data;
    } access_t;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] direction;
        logic [7:0] port_out;
    } side_regs_t;

endpackage

// ==== design/pia_host_bus_register_select.sv ====
// host bus interface, register select and register file of the adapter
`timescale 1ns/1ps
module pia_host_bus_register_select (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // processor bus pins
    input wire logic phase_two_clk_i,
    input wire logic select_high_a_i,
    input wire logic select_high_b_i,
    input wire logic select_low_n_i,
    input wire logic reg_sel_hi_i,
    input wire logic reg_sel_lo_i,
    input wire logic read_write_n_i,
    input wire logic reset_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    // flag set pulses from the control-line logic, [1]=line one
    input wire logic [1:0] side_a_flag_set_i,
    input wire logic [1:0] side_b_flag_set_i,
    // register contents toward the port and control-line logic
    output logic [7:0] side_a_control_o,
    output logic [7:0] side_b_control_o,
    output logic [7:0] side_a_direction_o,
    output logic [7:0] side_b_direction_o,
    output logic [7:0] side_a_port_out_o,
    output logic [7:0] side_b_port_out_o
);

    localparam int PIN_W = $bits(pia_pkg::host_pins_t);

    // ------------------------------------------------------------
    // pin synchroniser and agreement filter
    // ------------------------------------------------------------
    logic [PIN_W-1:0] raw_pins;
    logic [PIN_W-1:0] sync1_q;
    logic [PIN_W-1:0] sync2_q;
    logic [PIN_W-1:0] sync3_q;
    logic [PIN_W-1:0] filt_q;
    logic [PIN_W-1:0] filt_d;
    pia_pkg::host_pins_t pins;

    // pack the pins once so every bit sees the same stages
    always_comb begin
        raw_pins = {phase_two_clk_i, select_high_a_i, select_high_b_i,
                    select_low_n_i, reg_sel_hi_i, reg_sel_lo_i,
                    read_write_n_i, reset_n_i, data_i};
    end

    // a bit moves only when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_filter
            assign filt_d[gi] = (sync2_q[gi] == sync3_q[gi]) ?
                                sync3_q[gi] : filt_q[gi];
        end
    endgenerate

    // stage one feeds stage two only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_q <= pia_pkg::PINS_RESET;
            sync2_q <= pia_pkg::PINS_RESET;
            sync3_q <= pia_pkg::PINS_RESET;
            filt_q <= pia_pkg::PINS_RESET;
        end else if (ce_i) begin
            sync1_q <= raw_pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= filt_d;
        end
    end

    assign pins = pia_pkg::host_pins_t'(filt_q);

    // ------------------------------------------------------------
    // select and address decode
    // ------------------------------------------------------------
    pia_pkg::side_regs_t side_a_q;
    pia_pkg::side_regs_t side_a_d;
    pia_pkg::side_regs_t side_b_q;
    pia_pkg::side_regs_t side_b_d;
    logic sel_live;
    pia_pkg::target_t tgt_live;

    // the access bit of each side chooses port or direction register
    function automatic pia_pkg::target_t decode(input logic [1:0] rs,
                                                input logic a_acc,
                                                input logic b_acc);
        pia_pkg::target_t t;
        t = pia_pkg::TGT_CTL_B;
        if (rs == pia_pkg::RS_SIDE_A) begin
            t = a_acc ? pia_pkg::TGT_PORT_A : pia_pkg::TGT_DIR_A; // see RULE2
        end else if (rs == pia_pkg::RS_CTL_A) begin
            t = pia_pkg::TGT_CTL_A; // see RULE4
        end else if (rs == pia_pkg::RS_SIDE_B) begin
            t = b_acc ? pia_pkg::TGT_PORT_B : pia_pkg::TGT_DIR_B; // see RULE3
        end else begin
            t = pia_pkg::TGT_CTL_B; // see RULE4
        end
        return t;
    endfunction

    // three-line select and joint decode from both controls
    always_comb begin
        sel_live = pins.select_high_a & pins.select_high_b &
                   ~pins.select_low_n; // see RULE1
        tgt_live = decode({pins.reg_sel_hi, pins.reg_sel_lo},
                          side_a_q.control[pia_pkg::CTL_DIR_ACCESS_BIT],
                          side_b_q.control[pia_pkg::CTL_DIR_ACCESS_BIT]);
        // see RULE11
    end

    // ------------------------------------------------------------
    // phase-two sequencer and register file
    // ------------------------------------------------------------
    pia_pkg::phase_t phase_q;
    pia_pkg::phase_t phase_d;
    pia_pkg::access_t acc_q;
    pia_pkg::access_t acc_d;
    logic [7:0] buf_q;
    logic [7:0] buf_d;
    logic oe_q;
    logic oe_d;
    logic [1:0] clr_a;
    logic [1:0] clr_b;
    logic [7:0] rd_val;

    // read mux for the bus buffer
    always_comb begin
        case (tgt_live)
            pia_pkg::TGT_DIR_A: rd_val = side_a_q.direction;
            pia_pkg::TGT_PORT_A: rd_val = side_a_q.port_out;
            pia_pkg::TGT_CTL_A: rd_val = side_a_q.control;
            pia_pkg::TGT_DIR_B: rd_val = side_b_q.direction;
            pia_pkg::TGT_PORT_B: rd_val = side_b_q.port_out;
            default: rd_val = side_b_q.control;
        endcase
    end

    // writes wait for the trailing edge so port lines change cleanly
    always_comb begin
        phase_d = phase_q;
        acc_d = acc_q;
        side_a_d = side_a_q;
        side_b_d = side_b_q;
        clr_a = 2'b00;
        clr_b = 2'b00;
        case (phase_q)
            pia_pkg::PH_LOW: begin
                if (pins.phase_two_clk) begin // see RULE6
                    phase_d = pia_pkg::PH_HIGH;
                    acc_d.selected = sel_live;
                    acc_d.read = pins.read_write_n; // see RULE12
                    acc_d.target = tgt_live;
                    acc_d.data = pins.data;
                end
            end
            pia_pkg::PH_HIGH: begin
                if (pins.phase_two_clk) begin
                    // input register follows the bus until the edge
                    acc_d.data = pins.data; // see RULE9
                end else begin
                    phase_d = pia_pkg::PH_LOW;
                    if (acc_q.selected && acc_q.read) begin
                        // reading a port register acknowledges its flags
                        if (acc_q.target == pia_pkg::TGT_PORT_A) begin
                            clr_a = 2'b11;
                        end
                        if (acc_q.target == pia_pkg::TGT_PORT_B) begin
                            clr_b = 2'b11;
                        end
                    end else if (acc_q.selected) begin
                        // one target only, all others keep value
                        case (acc_q.target) // see RULE15 see RULE16
                            pia_pkg::TGT_DIR_A:
                                side_a_d.direction = acc_q.data;
                            pia_pkg::TGT_PORT_A:
                                side_a_d.port_out = acc_q.data;
                            pia_pkg::TGT_CTL_A:
                                side_a_d.control =
                                    (side_a_q.control &
                                     ~pia_pkg::CTL_WRITE_MASK) |
                                    (acc_q.data & pia_pkg::CTL_WRITE_MASK);
                            pia_pkg::TGT_DIR_B:
                                side_b_d.direction = acc_q.data;
                            pia_pkg::TGT_PORT_B:
                                side_b_d.port_out = acc_q.data;
                            default:
                                side_b_d.control =
                                    (side_b_q.control &
                                     ~pia_pkg::CTL_WRITE_MASK) |
                                    (acc_q.data & pia_pkg::CTL_WRITE_MASK);
                        endcase
                    end
                end
            end
            default: phase_d = pia_pkg::PH_LOW;
        endcase
        // flags: a set in the clearing cycle wins
        side_a_d.control[7:6] = (side_a_d.control[7:6] & ~clr_a) |
                                side_a_flag_set_i; // see RULE5
        side_b_d.control[7:6] = (side_b_d.control[7:6] & ~clr_b) |
                                side_b_flag_set_i; // see RULE5
        // reset pin clears all registers, so port lines turn inputs
        if (!pins.reset_n) begin // see RULE13
            phase_d = pia_pkg::PH_LOW;
            acc_d = '0;
            side_a_d = '0;
            side_b_d = '0;
        end
    end

    // bus drive: only during phase two of a selected read
    always_comb begin
        oe_d = pins.phase_two_clk & sel_live & pins.read_write_n &
               pins.reset_n; // see RULE8 see RULE9 see RULE10
        buf_d = oe_d ? rd_val : buf_q; // see RULE8
    end

    // register stage for sequencer, register file and bus buffer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase_q <= pia_pkg::PH_LOW;
            acc_q <= '0;
            side_a_q <= '0;
            side_b_q <= '0;
            buf_q <= pia_pkg::REG_RESET;
            oe_q <= 1'b0;
        end else if (ce_i) begin
            phase_q <= phase_d;
            acc_q <= acc_d;
            side_a_q <= side_a_d;
            side_b_q <= side_b_d;
            buf_q <= buf_d;
            oe_q <= oe_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from registers
    // ------------------------------------------------------------
    assign data_o = buf_q;
    assign data_oe_o = oe_q;
    assign side_a_control_o = side_a_q.control;
    assign side_b_control_o = side_b_q.control;
    // a one bit makes the matching port line an output; see RULE14
    assign side_a_direction_o = side_a_q.direction;
    assign side_b_direction_o = side_b_q.direction;
    assign side_a_port_out_o = side_a_q.port_out;
    assign side_b_port_out_o = side_b_q.port_out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    unselected_float_a: assert property ( // see RULE10
        ce_i && !sel_live |=> !data_oe_o)
        else $error("data driven while unselected");

    read_drives_ctl_a: assert property ( // see RULE8
        ce_i && sel_live && pins.phase_two_clk && pins.read_write_n &&
        pins.reset_n && tgt_live == pia_pkg::TGT_CTL_A
        |=> data_oe_o && data_o == $past(side_a_q.control))
        else $error("read did not drive side A control");

    write_keeps_float_a: assert property ( // see RULE9
        ce_i && !pins.read_write_n |=> !data_oe_o)
        else $error("data driven during a write");

    decode_side_a_a: assert property ( // see RULE2
        {pins.reg_sel_hi, pins.reg_sel_lo} == pia_pkg::RS_SIDE_A
        |-> tgt_live == (side_a_q.control[2] ? pia_pkg::TGT_PORT_A :
                                                pia_pkg::TGT_DIR_A))
        else $error("side A code decoded wrongly");

    decode_side_b_a: assert property ( // see RULE3
        {pins.reg_sel_hi, pins.reg_sel_lo} == pia_pkg::RS_SIDE_B
        |-> tgt_live == (side_b_q.control[2] ? pia_pkg::TGT_PORT_B :
                                                pia_pkg::TGT_DIR_B))
        else $error("side B code decoded wrongly");

    decode_control_a: assert property ( // see RULE4
        {pins.reg_sel_hi, pins.reg_sel_lo} == pia_pkg::RS_CTL_B
        |-> tgt_live == pia_pkg::TGT_CTL_B)
        else $error("control B code decoded wrongly");

    trailing_write_a: assert property ( // see RULE15
        ce_i && phase_q == pia_pkg::PH_HIGH && !pins.phase_two_clk &&
        pins.reset_n && acc_q.selected && !acc_q.read &&
        acc_q.target == pia_pkg::TGT_PORT_A
        |=> side_a_port_out_o == $past(acc_q.data) &&
            $stable(side_b_port_out_o) && $stable(side_a_direction_o))
        else $error("trailing edge write wrong"); // see RULE16

    no_write_low_a: assert property ( // see RULE6
        ce_i && phase_q == pia_pkg::PH_LOW && pins.reset_n
        |=> $stable(side_a_port_out_o) && $stable(side_b_direction_o))
        else $error("register changed outside phase two");

    pin_reset_clear_a: assert property ( // see RULE13
        ce_i && !pins.reset_n
        |=> side_a_control_o == 8'h00 && side_b_direction_o == 8'h00)
        else $error("reset pin did not clear registers");

    flag_set_wins_a: assert property ( // see RULE5
        ce_i && pins.reset_n && side_a_flag_set_i[1]
        |=> side_a_control_o[pia_pkg::CTL_FLAG1_BIT])
        else $error("line one flag not set");

endmodule

// ==== test/host_cpu_model.sv ====
// processor bus master model that drives the phase-two protocol
`timescale 1ns/1ps
module host_cpu_model (
    // clock
    input wire logic clk_i,
    // device side of the data bus
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_i,
    // pins toward the device
    output pia_pkg::host_pins_t pins_o
);
    // ------------------------------------------------------------
    // pin drivers and wire level of the data bus
    // ------------------------------------------------------------
    pia_pkg::host_pins_t drv_q = pia_pkg::host_pins_t'(pia_pkg::PINS_RESET);
    logic cpu_oe = 1'b0;
    logic [7:0] last_q = 8'h00;
    logic [7:0] bus;

    // a released bus has no pull, so it shows the inverse of last level
    always_comb begin
        if (dev_oe_i) begin
            bus = dev_data_i;
        end else if (cpu_oe) begin
            bus = drv_q.data;
        end else begin
            bus = ~last_q;
        end
        pins_o = drv_q;
        pins_o.data = bus;
    end

    // remember the level so a floating bus keeps changing
    always @(posedge clk_i) begin
        last_q <= bus;
    end

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // address first, then phase two high for eight clocks
    task automatic open_cycle(input logic [2:0] sel, input logic [1:0] rs,
        input logic rd, input logic [7:0] wdata,
        output logic [7:0] rdata, output logic oe_seen);
        @(posedge clk_i);
        {drv_q.select_high_a, drv_q.select_high_b} <= sel[2:1];
        drv_q.select_low_n <= sel[0];
        {drv_q.reg_sel_hi, drv_q.reg_sel_lo} <= rs;
        drv_q.read_write_n <= rd;
        drv_q.data <= wdata;
        cpu_oe <= !rd;
        @(posedge clk_i);
        drv_q.phase_two_clk <= 1'b1;
        oe_seen = 1'b0;
        repeat (8) begin
            @(posedge clk_i);
            #1;
            oe_seen |= dev_oe_i;
        end
        rdata = dev_data_i;
    endtask

    // trailing edge, hold eight clocks, then release the bus
    task automatic close_cycle();
        @(posedge clk_i);
        drv_q.phase_two_clk <= 1'b0;
        repeat (8) @(posedge clk_i);
        drv_q.select_high_a <= 1'b0;
        drv_q.select_low_n <= 1'b1;
        cpu_oe <= 1'b0;
    endtask

    // reset pin level
    task automatic set_reset_pin(input logic v);
        @(posedge clk_i);
        drv_q.reset_n <= v;
    endtask
endmodule

// ==== test/pia_host_bus_register_select_tb_top.sv ====
// self-checking testbench for the host bus and register select block
`timescale 1ns/1ps
module pia_host_bus_register_select_tb_top;
    // ------------------------------------------------------------
    // signals, expected registers: ctl a, ctl b, dir a, dir b, out a, out b
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_ON = 3'b110;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce = 1'b1;
    logic [1:0] flag_a = 2'b00;
    logic [1:0] flag_b = 2'b00;
    pia_pkg::host_pins_t pins;
    logic [7:0] data_o;
    logic data_oe_o;
    logic [7:0] regs_o [6];
    logic [7:0] exp_r [6] = '{default: 8'h00};
    int fails = 0;
    int checks_done = 0;

    pia_host_bus_register_select dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
        .phase_two_clk_i(pins.phase_two_clk),
        .select_high_a_i(pins.select_high_a),
        .select_high_b_i(pins.select_high_b),
        .select_low_n_i(pins.select_low_n),
        .reg_sel_hi_i(pins.reg_sel_hi), .reg_sel_lo_i(pins.reg_sel_lo),
        .read_write_n_i(pins.read_write_n), .reset_n_i(pins.reset_n),
        .data_i(pins.data), .data_o(data_o), .data_oe_o(data_oe_o),
        .side_a_flag_set_i(flag_a), .side_b_flag_set_i(flag_b),
        .side_a_control_o(regs_o[0]), .side_b_control_o(regs_o[1]),
        .side_a_direction_o(regs_o[2]), .side_b_direction_o(regs_o[3]),
        .side_a_port_out_o(regs_o[4]), .side_b_port_out_o(regs_o[5])
    );

    host_cpu_model cpu_u (
        .clk_i(clk_i), .dev_data_i(data_o), .dev_oe_i(data_oe_o),
        .pins_o(pins)
    );

    // 250 mhz clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_regs();
        for (int i = 0; i < 6; i++) begin
            check($sformatf("register %0d", i), regs_o[i], exp_r[i]);
        end
    endtask

    // register index addressed by a select code, from the expected model
    function automatic int tgt(input logic [1:0] rs);
        case (rs)
            pia_pkg::RS_CTL_A: tgt = 0;
            pia_pkg::RS_CTL_B: tgt = 1;
            pia_pkg::RS_SIDE_A: tgt = exp_r[0][2] ? 4 : 2;
            default: tgt = exp_r[1][2] ? 5 : 3;
        endcase
    endfunction

    task automatic wr(input logic [2:0] sel, input logic [1:0] rs,
        input logic [7:0] d);
        logic [7:0] rv;
        logic oe;
        int t;
        t = tgt(rs);
        cpu_u.open_cycle(sel, rs, 1'b0, d, rv, oe);
        check_regs();
        check("write drive", {7'h00, oe}, 8'h00);
        cpu_u.close_cycle();
        #1;
        if (sel == SEL_ON) begin
            // flag bits are status, a write cannot touch them
            exp_r[t] = rs[0] ? ((d & 8'h3F) | (exp_r[t] & 8'hC0)) : d;
        end
        check_regs();
    endtask

    task automatic rd(input logic [2:0] sel, input logic [1:0] rs);
        logic [7:0] rv;
        logic oe;
        int t;
        t = tgt(rs);
        cpu_u.open_cycle(sel, rs, 1'b1, 8'h00, rv, oe);
        if (sel == SEL_ON) begin
            check("read data", rv, exp_r[t]);
        end
        check("read drive", {7'h00, oe},
              {7'h00, sel == SEL_ON});
        cpu_u.close_cycle();
        #1;
        check("idle drive", {7'h00, data_oe_o}, 8'h00);
        // a port register read clears that side's flags
        if (sel == SEL_ON && t >= 4) begin
            exp_r[t - 4] &= 8'h3F;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_select();
        wr(SEL_ON, pia_pkg::RS_CTL_A, 8'h00);
        wr(SEL_ON, pia_pkg::RS_SIDE_A, 8'h5A);
        wr(SEL_ON, pia_pkg::RS_CTL_B, 8'h00);
        wr(SEL_ON, pia_pkg::RS_SIDE_B, 8'hC3);
        wr(SEL_ON, pia_pkg::RS_CTL_A, 8'hFF);
        wr(SEL_ON, pia_pkg::RS_SIDE_A, 8'hA5);
        wr(SEL_ON, pia_pkg::RS_CTL_B, 8'h04);
        wr(SEL_ON, pia_pkg::RS_SIDE_B, 8'h3C);
        for (int i = 0; i < 4; i++) begin
            rd(SEL_ON, 2'(i));
        end
        wr(SEL_ON, pia_pkg::RS_CTL_A, 8'h00);
        wr(SEL_ON, pia_pkg::RS_CTL_B, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rd(SEL_ON, 2'(i));
        end
        $display("test select done");
    endtask

    task automatic test_unselected();
        logic [2:0] offs [4] = '{3'b010, 3'b100, 3'b111, 3'b000};
        foreach (offs[i]) begin
            wr(offs[i], pia_pkg::RS_CTL_A, 8'h2C);
            rd(offs[i], pia_pkg::RS_CTL_B);
        end
        $display("test unselected done");
    endtask

    task automatic test_flags();
        wr(SEL_ON, pia_pkg::RS_CTL_A, 8'h04);
        wr(SEL_ON, pia_pkg::RS_CTL_B, 8'h04);
        @(posedge clk_i);
        flag_a <= 2'b10;
        flag_b <= 2'b01;
        @(posedge clk_i);
        flag_a <= 2'b00;
        flag_b <= 2'b00;
        #1;
        exp_r[0] |= 8'h80;
        exp_r[1] |= 8'h40;
        check_regs();
        // the other line of each side, so no flag bit goes untested
        @(posedge clk_i);
        flag_a <= 2'b01;
        flag_b <= 2'b10;
        @(posedge clk_i);
        flag_a <= 2'b00;
        flag_b <= 2'b00;
        #1;
        exp_r[0] |= 8'h40;
        exp_r[1] |= 8'h80;
        check_regs();
        rd(SEL_ON, pia_pkg::RS_CTL_A);
        rd(SEL_ON, pia_pkg::RS_CTL_B);
        wr(SEL_ON, pia_pkg::RS_CTL_B, 8'hFB);
        rd(SEL_ON, pia_pkg::RS_SIDE_A);
        rd(SEL_ON, pia_pkg::RS_CTL_A);
        $display("test flags done");
    endtask

    // a whole bus cycle while frozen must leave every register alone
    task automatic test_enable();
        logic [7:0] rv;
        logic oe;
        @(posedge clk_i);
        ce <= 1'b0;
        cpu_u.open_cycle(SEL_ON, pia_pkg::RS_CTL_A, 1'b0, 8'h3B, rv, oe);
        cpu_u.close_cycle();
        @(posedge clk_i);
        ce <= 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
        check_regs();
        check("frozen drive", {7'h00, data_oe_o}, 8'h00);
        $display("test enable done");
    endtask

    task automatic test_reset_pin();
        cpu_u.set_reset_pin(1'b0);
        repeat (10) @(posedge clk_i);
        cpu_u.set_reset_pin(1'b1);
        repeat (8) @(posedge clk_i);
        #1;
        exp_r = '{default: 8'h00};
        check_regs();
        $display("test reset pin done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        check_regs();
        check("reset drive", {7'h00, data_oe_o}, 8'h00);
        $display("test reset done");
        test_select();
        test_unselected();
        test_flags();
        test_enable();
        test_reset_pin();
        final_report();
    end

    initial begin
        #400000;
        fails++;
        final_report();
    end
endmodule
